// ==== include/crbc_pkg.sv ====
// package of offsets, field positions, reset values and codes for the routing/bias register bank
package crbc_pkg;
    // ------------------------------------------------------------
    // register word indices on the control port
    // ------------------------------------------------------------
    localparam logic [6:0] CRBC_ADDR_BYPASS_SRC_ONE = 7'h1c;
    localparam logic [6:0] CRBC_ADDR_BYPASS_SRC_TWO = 7'h1d;
    localparam logic [6:0] CRBC_ADDR_ADC_SEL = 7'h1e;
    localparam logic [6:0] CRBC_ADDR_AMP_EN = 7'h1f;
    localparam logic [6:0] CRBC_ADDR_OUT_MUX_ONE = 7'h20;
    localparam logic [6:0] CRBC_ADDR_OUT_MUX_TWO = 7'h21;
    localparam logic [6:0] CRBC_ADDR_OUT_EN_TRI = 7'h22;
    localparam logic [6:0] CRBC_ADDR_BIAS = 7'h23;
    localparam logic [6:0] CRBC_ADDR_AUTO_INC = 7'h1b;
    localparam logic [6:0] CRBC_ADDR_ONE = 7'h01;

    // ------------------------------------------------------------
    // implemented-bit masks
    // ------------------------------------------------------------
    localparam logic [15:0] CRBC_MASK_BYPASS_ONE = 16'h0fff;
    localparam logic [15:0] CRBC_MASK_BYPASS_TWO = 16'h0fff;
    localparam logic [15:0] CRBC_MASK_ADC_SEL = 16'h07ff;
    localparam logic [15:0] CRBC_MASK_AMP_EN = 16'h00ff;
    localparam logic [15:0] CRBC_MASK_OUT_MUX = 16'h01ff;
    localparam logic [15:0] CRBC_MASK_OUT_EN_TRI = 16'h3fff;
    localparam logic [15:0] CRBC_MASK_BIAS = 16'h00ff;
    localparam logic [15:0] CRBC_MASK_AUTO_INC = 16'h0078;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] CRBC_RST_BYPASS = 16'h0000;
    localparam logic [15:0] CRBC_RST_ADC_SEL = 16'h0280;
    localparam logic [15:0] CRBC_RST_AMP_EN = 16'h0000;
    localparam logic [15:0] CRBC_RST_OUT_MUX_ONE = 16'h0088;
    localparam logic [15:0] CRBC_RST_OUT_MUX_TWO = 16'h0163;
    localparam logic [15:0] CRBC_RST_OUT_EN_TRI = 16'h0040;
    localparam logic [15:0] CRBC_RST_BIAS = 16'h0010;
    localparam logic [15:0] CRBC_RST_AUTO_INC = 16'h0048;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CRBC_BIT_RIGHT_AMP = 7;
    localparam int CRBC_BIT_LEFT_AMP = 6;
    localparam int CRBC_BIT_SOFT_RAMP = 4;
    localparam int CRBC_BIT_BIAS_EN = 5;
    localparam int CRBC_BIT_AUTO_INC = 3;
    localparam int CRBC_LSB_STRING = 6;

    // ------------------------------------------------------------
    // source codes
    // ------------------------------------------------------------
    localparam logic [3:0] CRBC_SRC_NONE = 4'h0;
    localparam logic [3:0] CRBC_SRC_VIN_FIRST = 4'h1;
    localparam logic [3:0] CRBC_SRC_VIN_LAST = 4'h5;
    localparam logic [3:0] CRBC_SRC_DAC_FIRST = 4'h9;
    localparam logic [3:0] CRBC_SRC_DAC_LAST = 4'hc;
    localparam logic [3:0] CRBC_ADC_LEFT_LAST = 4'h4;
    localparam logic [3:0] CRBC_ADC_RIGHT_FIRST = 4'h8;
    localparam logic [3:0] CRBC_ADC_RIGHT_LAST = 4'hc;

    // midrail string codes
    localparam logic [1:0] CRBC_STR_OFF = 2'h0;
    localparam logic [1:0] CRBC_STR_100K = 2'h1;
    localparam logic [1:0] CRBC_STR_500K = 2'h2;
    localparam logic [1:0] CRBC_STR_10K = 2'h3;
endpackage : crbc_pkg

// ==== rtl/crbc_regs.sv ====
// routing and bias control register bank behind the two-wire control port
`timescale 1ns/1ps
// Overview of operation
// RQ1: bypass source 0 none, 1-5 own inputs, 6-8 reserved, 9-12 converter outputs.
// RQ2: converter select 0-4 left inputs, 8-12 right inputs, others reserved.
// RQ3: converter amp enables at bits 7 and 6, 1 on, 0 off, reset 0.
// RQ4: midrail soft ramp bit 4 enables ramping, resets to 1.
// RQ5: clearing master bias powers down bias and converter-in midrail reference.
// RQ6: string select acts on output reference only: off, 100k, 500k, 10k.
// RQ7: auto-increment bit set advances address over multi-register accesses.
// RQ8: fields hold last write and read back; unimplemented bits read zero.
module crbc_regs
    import crbc_pkg::*;
(
    input wire logic clk_sys_i, // system clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic start_i, // new access: load address
    input wire logic [6:0] start_addr_i, // register address of the access
    input wire logic wr_i, // write strobe, one word
    input wire logic [15:0] wdata_i, // write data
    input wire logic rd_i, // read strobe, one word
    output logic [15:0] rdata_o, // registered read data
    output logic [6:0] cur_addr_o, // address of next word
    output logic [4:0] bypass_vin_o [6], // per amp one-hot input
    output logic [3:0] bypass_dac_o [6], // per amp one-hot converter
    output logic [5:0] bypass_none_o, // per amp no input
    output logic [4:0] left_converter_input_o, // left inputs picked by either select, ored
    output logic [4:0] right_converter_input_o, // right inputs picked by either select, ored
    output logic left_converter_amp_on_o, // left amp power
    output logic right_converter_amp_on_o, // right amp power
    output logic [1:0] adc_amp_gain_o, // input amp gain code
    output logic adc_switch_close_o, // input switches closed
    output logic [8:0] out_mux_one_o, // output mux fields
    output logic [8:0] out_mux_two_o, // output mux fields
    output logic [13:0] out_en_tri_o, // enables, clamp, tristates
    output logic master_bias_on_o, // master bias power
    output logic converter_in_midrail_ref_on_o, // input midrail reference power
    output logic [2:0] converter_out_midrail_ref_o, // one-hot 100k,500k,10k
    output logic midrail_soft_ramp_o, // soft ramp on
    output logic [3:0] bias_misc_o // buffer, fast, toggle, source bits
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [15:0] bypass_one_reg, bypass_two_reg, adc_sel_reg, amp_en_reg;
    logic [15:0] mux_one_reg, mux_two_reg, en_tri_reg, bias_reg, auto_reg;
    logic [6:0] addr_reg;
    logic [15:0] rdata_reg;

    // mask-aware write helper keeps unimplemented bits at zero (see RQ8)
    function automatic logic [15:0] crbc_wr(input logic [15:0] d, input logic [15:0] m);
        crbc_wr = d & m;
    endfunction : crbc_wr

    function automatic logic [4:0] crbc_onehot5(input logic [3:0] c, input logic [3:0] b);
        logic [3:0] i;
        i = c - b;
        crbc_onehot5 = 5'(5'h01 << i[2:0]);
    endfunction : crbc_onehot5

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire [6:0] acc_addr = start_i ? start_addr_i : addr_reg;
    wire hit_b1 = (acc_addr == CRBC_ADDR_BYPASS_SRC_ONE);
    wire hit_b2 = (acc_addr == CRBC_ADDR_BYPASS_SRC_TWO);
    wire hit_as = (acc_addr == CRBC_ADDR_ADC_SEL);
    wire hit_ae = (acc_addr == CRBC_ADDR_AMP_EN);
    wire hit_m1 = (acc_addr == CRBC_ADDR_OUT_MUX_ONE);
    wire hit_m2 = (acc_addr == CRBC_ADDR_OUT_MUX_TWO);
    wire hit_et = (acc_addr == CRBC_ADDR_OUT_EN_TRI);
    wire hit_bi = (acc_addr == CRBC_ADDR_BIAS);
    wire hit_ai = (acc_addr == CRBC_ADDR_AUTO_INC);
    wire auto_on = auto_reg[CRBC_BIT_AUTO_INC];

    // unmapped addresses read zero (see RQ8)
    wire [15:0] rd_mux =
        hit_b1 ? bypass_one_reg : hit_b2 ? bypass_two_reg :
        hit_as ? adc_sel_reg : hit_ae ? amp_en_reg :
        hit_m1 ? mux_one_reg : hit_m2 ? mux_two_reg :
        hit_et ? en_tri_reg : hit_bi ? bias_reg :
        hit_ai ? auto_reg : 16'h0000; // see RQ8

    // address steps after each word only while auto-increment is set
    wire step = (wr_i || rd_i) && auto_on; // see RQ7
    wire [6:0] addr_next = step ? 7'(acc_addr + CRBC_ADDR_ONE) : acc_addr; // see RQ7

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            bypass_one_reg <= CRBC_RST_BYPASS;
            bypass_two_reg <= CRBC_RST_BYPASS;
            adc_sel_reg <= CRBC_RST_ADC_SEL;
            amp_en_reg <= CRBC_RST_AMP_EN; // see RQ3
            mux_one_reg <= CRBC_RST_OUT_MUX_ONE;
            mux_two_reg <= CRBC_RST_OUT_MUX_TWO;
            en_tri_reg <= CRBC_RST_OUT_EN_TRI;
            bias_reg <= CRBC_RST_BIAS; // see RQ4
            auto_reg <= CRBC_RST_AUTO_INC;
        end
        else if (wr_i)
        begin
            if (hit_b1) bypass_one_reg <= crbc_wr(wdata_i, CRBC_MASK_BYPASS_ONE); // see RQ8
            if (hit_b2) bypass_two_reg <= crbc_wr(wdata_i, CRBC_MASK_BYPASS_TWO);
            if (hit_as) adc_sel_reg <= crbc_wr(wdata_i, CRBC_MASK_ADC_SEL);
            if (hit_ae) amp_en_reg <= crbc_wr(wdata_i, CRBC_MASK_AMP_EN); // see RQ3
            if (hit_m1) mux_one_reg <= crbc_wr(wdata_i, CRBC_MASK_OUT_MUX);
            if (hit_m2) mux_two_reg <= crbc_wr(wdata_i, CRBC_MASK_OUT_MUX);
            if (hit_et) en_tri_reg <= crbc_wr(wdata_i, CRBC_MASK_OUT_EN_TRI);
            if (hit_bi) bias_reg <= crbc_wr(wdata_i, CRBC_MASK_BIAS);
            if (hit_ai) auto_reg <= crbc_wr(wdata_i, CRBC_MASK_AUTO_INC);
        end
    end

    // address pointer and registered read data
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            addr_reg <= 7'h00;
            rdata_reg <= 16'h0000;
        end
        else
        begin
            addr_reg <= addr_next;
            if (rd_i) rdata_reg <= rd_mux; // see RQ8
        end
    end

    assign rdata_o = rdata_reg;
    assign cur_addr_o = addr_reg;

    // ------------------------------------------------------------
    // bypass source decoders, three per register
    // ------------------------------------------------------------
    wire [3:0] src_code [6];
    assign src_code[0] = bypass_one_reg[3:0];
    assign src_code[1] = bypass_one_reg[7:4];
    assign src_code[2] = bypass_one_reg[11:8];
    assign src_code[3] = bypass_two_reg[3:0];
    assign src_code[4] = bypass_two_reg[7:4];
    assign src_code[5] = bypass_two_reg[11:8];

    for (genvar g = 0; g < 6; g++)
    begin : g_src
        crbc_src_decode u_dec (
            .code_i(src_code[g]),
            .vin_o(bypass_vin_o[g]),
            .dac_o(bypass_dac_o[g]),
            .none_o(bypass_none_o[g]),
            .reserved_o()
        ); // see RQ1
    end

    // ------------------------------------------------------------
    // converter input select; reserved codes select nothing
    // ------------------------------------------------------------
    wire [3:0] left_sel = adc_sel_reg[3:0];
    wire [3:0] right_sel = adc_sel_reg[7:4];
    function automatic logic [9:0] crbc_adc_dec(input logic [3:0] c);
        crbc_adc_dec = 10'h000;
        if (c <= CRBC_ADC_LEFT_LAST)
            crbc_adc_dec[4:0] = crbc_onehot5(c, CRBC_SRC_NONE);
        else if (c >= CRBC_ADC_RIGHT_FIRST && c <= CRBC_ADC_RIGHT_LAST)
            crbc_adc_dec[9:5] = crbc_onehot5(c, CRBC_ADC_RIGHT_FIRST);
    endfunction : crbc_adc_dec
    // either select may pick either side, so both sides are ored
    wire [9:0] left_dec = crbc_adc_dec(left_sel); // see RQ2
    wire [9:0] right_dec = crbc_adc_dec(right_sel); // see RQ2
    assign left_converter_input_o = left_dec[4:0] | right_dec[4:0]; // see RQ2
    assign right_converter_input_o = left_dec[9:5] | right_dec[9:5]; // see RQ2
    assign adc_amp_gain_o = adc_sel_reg[9:8];
    assign adc_switch_close_o = adc_sel_reg[10];

    // ------------------------------------------------------------
    // amp enables, output routing
    // ------------------------------------------------------------
    assign left_converter_amp_on_o = amp_en_reg[CRBC_BIT_LEFT_AMP]; // see RQ3
    assign right_converter_amp_on_o = amp_en_reg[CRBC_BIT_RIGHT_AMP]; // see RQ3
    assign out_mux_one_o = mux_one_reg[8:0];
    assign out_mux_two_o = mux_two_reg[8:0];
    assign out_en_tri_o = en_tri_reg[13:0];

    // ------------------------------------------------------------
    // bias and midrail
    // ------------------------------------------------------------
    wire bias_on = bias_reg[CRBC_BIT_BIAS_EN];
    wire [1:0] str_sel = bias_reg[CRBC_LSB_STRING +: 2];
    assign master_bias_on_o = bias_on; // see RQ5
    assign converter_in_midrail_ref_on_o = bias_on; // see RQ5
    // string code touches only the output reference (see RQ6)
    assign converter_out_midrail_ref_o = {str_sel == CRBC_STR_10K,
                                          str_sel == CRBC_STR_500K,
                                          str_sel == CRBC_STR_100K}; // see RQ6
    assign midrail_soft_ramp_o = bias_reg[CRBC_BIT_SOFT_RAMP]; // see RQ4
    assign bias_misc_o = bias_reg[3:0];
endmodule : crbc_regs

// ==== rtl/crbc_src_decode.sv ====
// one-hot decoder for a bypass amplifier 4-bit source field
`timescale 1ns/1ps
module crbc_src_decode
    import crbc_pkg::*;
(
    input wire logic [3:0] code_i, // source field
    output logic [4:0] vin_o, // one-hot analogue input 1..5
    output logic [3:0] dac_o, // one-hot converter channel 1..4
    output logic none_o, // no input selected
    output logic reserved_o // reserved code
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire is_vin = (code_i >= CRBC_SRC_VIN_FIRST) && (code_i <= CRBC_SRC_VIN_LAST);
    wire is_dac = (code_i >= CRBC_SRC_DAC_FIRST) && (code_i <= CRBC_SRC_DAC_LAST);
    wire [3:0] vin_idx = code_i - CRBC_SRC_VIN_FIRST;
    wire [3:0] dac_idx = code_i - CRBC_SRC_DAC_FIRST;

    // codes 0110..1000 and above 1100 select nothing (see RQ1)
    assign vin_o = is_vin ? 5'(5'h01 << vin_idx[2:0]) : 5'h00; // see RQ1
    assign dac_o = is_dac ? 4'(4'h1 << dac_idx[1:0]) : 4'h0; // see RQ1
    assign none_o = (code_i == CRBC_SRC_NONE); // see RQ1
    assign reserved_o = !is_vin && !is_dac && !none_o;
endmodule : crbc_src_decode

// ==== test/crbc_assertions.sv ====
// assertion checker for the routing and bias register bank
`timescale 1ns/1ps
module crbc_assertions
    import crbc_pkg::*;
(
    input wire logic clk_sys_i, // clock
    input wire logic rst_n_i, // reset
    input wire logic start_i, // new access
    input wire logic [6:0] start_addr_i, // address
    input wire logic wr_i, // write
    input wire logic [15:0] wdata_i, // write data
    input wire logic rd_i, // read
    input wire logic [15:0] rdata_o, // read data
    input wire logic [6:0] cur_addr_o, // next address
    input wire logic left_converter_amp_on_o, // left amp
    input wire logic right_converter_amp_on_o, // right amp
    input wire logic [8:0] out_mux_one_o, // mux
    input wire logic master_bias_on_o, // bias
    input wire logic converter_in_midrail_ref_on_o, // input ref
    input wire logic [2:0] converter_out_midrail_ref_o, // string
    input wire logic midrail_soft_ramp_o, // ramp
    input wire logic [3:0] bias_misc_o // misc
);
    logic auto_reg;
    logic [6:0] addr_now;
    logic [1:0] str_code;
    logic bias_wr;
    // effective address and the string code rebuilt from its one-hot form
    assign addr_now = start_i ? start_addr_i : cur_addr_o;
    assign str_code = {converter_out_midrail_ref_o[2] | converter_out_midrail_ref_o[1],
                       converter_out_midrail_ref_o[2] | converter_out_midrail_ref_o[0]};
    assign bias_wr = wr_i && addr_now == CRBC_ADDR_BIAS;
    // shadow of the step bit, which never reaches a port
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
        if (!rst_n_i)
            auto_reg <= CRBC_RST_AUTO_INC[CRBC_BIT_AUTO_INC];
        else if (wr_i && addr_now == CRBC_ADDR_AUTO_INC)
            auto_reg <= wdata_i[CRBC_BIT_AUTO_INC];

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    a_bias_ref_tie: assert property (master_bias_on_o == converter_in_midrail_ref_on_o)
        else $error("bias and input reference differ");
    a_bias_write: assert property (bias_wr |=> master_bias_on_o == $past(wdata_i[5]))
        else $error("bias enable not taken");
    a_soft_ramp_write: assert property (bias_wr |=> midrail_soft_ramp_o == $past(wdata_i[4]))
        else $error("soft ramp not taken");
    a_string_write: assert property (bias_wr |=> str_code == $past(wdata_i[7:6])
        && $onehot0(converter_out_midrail_ref_o)) else $error("string select wrong");
    a_amp_write: assert property (wr_i && addr_now == CRBC_ADDR_AMP_EN |=>
        {right_converter_amp_on_o, left_converter_amp_on_o} == $past(wdata_i[7:6]))
        else $error("amp enables wrong");
    a_mux_write: assert property (wr_i && addr_now == CRBC_ADDR_OUT_MUX_ONE |=>
        out_mux_one_o == $past(wdata_i[8:0])) else $error("mux field not held");
    a_addr_step: assert property ((wr_i || rd_i) && !(wr_i && addr_now == CRBC_ADDR_AUTO_INC)
        |=> cur_addr_o == $past(addr_now) + {6'h00, $past(auto_reg)}) else $error("address step");
    a_read_bias: assert property (rd_i && !wr_i && addr_now == CRBC_ADDR_BIAS |=>
        rdata_o == {8'h00, $past(str_code), $past(master_bias_on_o), $past(midrail_soft_ramp_o),
        $past(bias_misc_o)}) else $error("bias readback wrong");
    a_rdata_hold: assert property (!rd_i |=> $stable(rdata_o))
        else $error("read data moved");

    c_bias_write: cover property (bias_wr);
    c_burst_read: cover property (rd_i && !start_i);
    c_amp_write: cover property (wr_i && addr_now == CRBC_ADDR_AMP_EN);
endmodule : crbc_assertions

bind crbc_regs crbc_assertions crbc_assertions_i (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .start_i(start_i),
    .start_addr_i(start_addr_i),
    .wr_i(wr_i),
    .wdata_i(wdata_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .cur_addr_o(cur_addr_o),
    .left_converter_amp_on_o(left_converter_amp_on_o),
    .right_converter_amp_on_o(right_converter_amp_on_o),
    .out_mux_one_o(out_mux_one_o),
    .master_bias_on_o(master_bias_on_o),
    .converter_in_midrail_ref_on_o(converter_in_midrail_ref_on_o),
    .converter_out_midrail_ref_o(converter_out_midrail_ref_o),
    .midrail_soft_ramp_o(midrail_soft_ramp_o),
    .bias_misc_o(bias_misc_o)
);

// ==== test/crbc_host_model.sv ====
// host model: issues one word per call on the bank's access port
`timescale 1ns/1ps
module crbc_host_model
    import crbc_pkg::*;
(
    input wire logic clk_sys_i, // clock
    input wire logic [15:0] rdata_i, // bank read data
    output logic start_o, // new access
    output logic [6:0] start_addr_o, // access address
    output logic wr_o, // write strobe
    output logic [15:0] wdata_o, // write data
    output logic rd_o // read strobe
);
    // quiet bus until the first request
    initial {start_o, start_addr_o, wr_o, wdata_o, rd_o} = '0;

    // one word: held over one rising edge, read data taken just after it
    task automatic word(input logic st, input logic [6:0] a, input logic w,
                        input logic [15:0] d, output logic [15:0] q);
        start_o = st;
        start_addr_o = a;
        wr_o = w;
        rd_o = !w;
        wdata_o = d;
        @(posedge clk_sys_i);
        #1;
        q = rdata_i;
    endtask : word

    // released lines flip so a stale value is never mistaken for data
    task automatic idle();
        start_o = 1'b0;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = ~wdata_o;
        start_addr_o = ~start_addr_o;
    endtask : idle
endmodule : crbc_host_model

// ==== test/tb.sv ====
// self-checking bench for the routing and bias register bank
`timescale 1ns/1ps
module tb;
    import crbc_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic start, wr, rd, lamp, ramp, sw, mb, cir, sr;
    logic [6:0] sa, cur;
    logic [15:0] wd, rdata, q;
    logic [4:0] bvin [6];
    logic [3:0] bdac [6];
    logic [5:0] bnone;
    logic [4:0] lsel, rsel, ev;
    logic [3:0] ed, misc;
    logic [1:0] gain;
    logic [8:0] m1, m2;
    logic [13:0] et;
    logic [2:0] cor;
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;
    localparam logic [15:0] RST_TAB [6] = '{CRBC_RST_ADC_SEL, CRBC_RST_AMP_EN,
        CRBC_RST_OUT_MUX_ONE, CRBC_RST_OUT_MUX_TWO, CRBC_RST_OUT_EN_TRI, CRBC_RST_BIAS};
    localparam logic [15:0] MASK_TAB [6] = '{CRBC_MASK_ADC_SEL, CRBC_MASK_AMP_EN,
        CRBC_MASK_OUT_MUX, CRBC_MASK_OUT_MUX, CRBC_MASK_OUT_EN_TRI, CRBC_MASK_BIAS};

    // 200 MHz clock
    always #2.5 clk_sys_i = ~clk_sys_i;

    crbc_host_model crbc_host_model_i (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .start_o(start),
        .start_addr_o(sa), .wr_o(wr), .wdata_o(wd), .rd_o(rd));
    crbc_regs crbc_regs_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .start_i(start),
        .start_addr_i(sa), .wr_i(wr), .wdata_i(wd), .rd_i(rd), .rdata_o(rdata),
        .cur_addr_o(cur), .bypass_vin_o(bvin), .bypass_dac_o(bdac), .bypass_none_o(bnone),
        .left_converter_input_o(lsel), .right_converter_input_o(rsel),
        .left_converter_amp_on_o(lamp), .right_converter_amp_on_o(ramp),
        .adc_amp_gain_o(gain), .adc_switch_close_o(sw), .out_mux_one_o(m1),
        .out_mux_two_o(m2), .out_en_tri_o(et), .master_bias_on_o(mb),
        .converter_in_midrail_ref_on_o(cir), .converter_out_midrail_ref_o(cor),
        .midrail_soft_ramp_o(sr), .bias_misc_o(misc));

    // ----------------------------------------
    // checks and verdict
    // ----------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    task automatic put(input logic st, input logic [6:0] a, input logic [15:0] d);
        crbc_host_model_i.word(st, a, 1'b1, d, q);
    endtask : put

    task automatic get(input logic st, input logic [6:0] a);
        crbc_host_model_i.word(st, a, 1'b0, 16'h0000, q);
    endtask : get

    // cut a hang short; the whole run needs about 110 cycles
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            print_verdict();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (3) @(posedge clk_sys_i);
        #1;
        rst_n_i = 1'b1;
        // reset values read as one stepping burst
        for (int i = 0; i < 6; i++)
        begin
            get(i == 0, CRBC_ADDR_ADC_SEL);
            chk("reset value", RST_TAB[i], q);
        end
        get(1'b1, CRBC_ADDR_AUTO_INC);
        chk("step reset", CRBC_RST_AUTO_INC, q);
        // all ones in one burst: only implemented bits stick
        for (int i = 0; i < 6; i++)
            put(i == 0, CRBC_ADDR_ADC_SEL, 16'hffff);
        chk("mux one", 16'h01ff, {7'h00, m1});
        chk("mux two", 16'h01ff, {7'h00, m2});
        chk("enables tristates", 16'h3fff, {2'h0, et});
        for (int i = 0; i < 6; i++)
        begin
            get(i == 0, CRBC_ADDR_ADC_SEL);
            chk("masked word", MASK_TAB[i], q);
        end
        chk("next address", 16'h0024, {9'h000, cur});
        put(1'b1, 7'h30, 16'hffff);
        get(1'b1, 7'h30);
        chk("unmapped", 16'h0000, q);
        // step off: the address must stay put
        put(1'b1, CRBC_ADDR_AUTO_INC, 16'h0000);
        get(1'b1, CRBC_ADDR_BIAS);
        get(1'b0, CRBC_ADDR_BIAS);
        chk("repeat read", CRBC_MASK_BIAS, q);
        chk("held address", 16'h0023, {9'h000, cur});
        put(1'b1, CRBC_ADDR_AUTO_INC, 16'h0008);
        // every bypass and converter select code
        for (int c = 0; c < 16; c++)
        begin
            put(1'b1, CRBC_ADDR_BYPASS_SRC_ONE, {4'h0, c[3:0], c[3:0], c[3:0]});
            put(1'b1, CRBC_ADDR_BYPASS_SRC_TWO, {4'h0, c[3:0], c[3:0], c[3:0]});
            ev = (c >= 1 && c <= 5) ? 5'(1 << (c - 1)) : 5'h00;
            ed = (c >= 9 && c <= 12) ? 4'(1 << (c - 9)) : 4'h0;
            for (int k = 0; k < 6; k++)
            begin
                chk("bypass input", {11'h000, ev}, {11'h000, bvin[k]});
                chk("bypass dac", {12'h000, ed}, {12'h000, bdac[k]});
            end
            // reserved and routed codes must both leave the no-input flags low
            chk("bypass none", (c == 0) ? 16'h003f : 16'h0000, {10'h000, bnone});
            put(1'b1, CRBC_ADDR_ADC_SEL, {5'h00, c[2:0], c[3:0], c[3:0]});
            ev = (c <= 4) ? 5'(1 << c) : 5'h00;
            chk("left select", {11'h000, ev}, {11'h000, lsel});
            ev = (c >= 8 && c <= 12) ? 5'(1 << (c - 8)) : 5'h00;
            chk("right select", {11'h000, ev}, {11'h000, rsel});
            chk("gain switch", {13'h0000, c[2:0]}, {13'h0000, sw, gain});
            // bias fields: string, master bias, soft ramp
            put(1'b1, CRBC_ADDR_BIAS, {8'h00, c[3:0], 4'ha});
            ed = (c[3:2] == 2'h0) ? 4'h0 : 4'(1 << (c[3:2] - 1));
            chk("string", {12'h000, ed}, {13'h0000, cor});
            chk("bias pair", {14'h0000, c[1], c[1]}, {14'h0000, mb, cir});
            chk("soft ramp", {15'h0000, c[0]}, {15'h0000, sr});
            chk("bias misc", 16'h000a, {12'h000, misc});
            put(1'b1, CRBC_ADDR_AMP_EN, {8'h00, c[1:0], 6'h00});
            chk("amp enables", {14'h0000, c[1:0]}, {14'h0000, ramp, lamp});
        end
        crbc_host_model_i.idle();
        @(posedge clk_sys_i);
        print_verdict();
    end
endmodule : tb
